// File: hdl/sbc_pkg.sv
// Package of operation codes, control register indices and constants.
package sbc_pkg;

	// ****************************************************************
	// Widths and layouts
	// ****************************************************************
	localparam int XLEN       = 32;
	localparam int SHAMT_W    = 5;
	localparam int IMM_W      = 16;
	localparam int CALL_IMM_W = 26;
	localparam int CTL_SEL_W  = 3;

	// Control register indices.
	localparam logic [CTL_SEL_W-1:0] CTL_STATUS  = 3'h0;
	localparam logic [CTL_SEL_W-1:0] CTL_ESTATUS = 3'h1;
	localparam logic [CTL_SEL_W-1:0] CTL_BSTATUS = 3'h2;

	// Reset values and instruction size.
	localparam logic [XLEN-1:0] STATUS_RST   = 32'h0000_0000;
	localparam logic [XLEN-1:0] ADDR_RST     = 32'h0000_0000;
	localparam logic [XLEN-1:0] INSN_BYTES   = 32'h0000_0004;

	// ****************************************************************
	// Operations
	// ****************************************************************
	typedef enum logic [5:0] {
		OP_NOP    = 6'h00, OP_ROL    = 6'h01, OP_ROLI   = 6'h02,
		OP_ROR    = 6'h03, OP_SLL    = 6'h04, OP_SLLI   = 6'h05,
		OP_SRL    = 6'h06, OP_SRLI   = 6'h07, OP_SRA    = 6'h08,
		OP_SRAI   = 6'h09, OP_CALL   = 6'h0a, OP_CALLR  = 6'h0b,
		OP_RET    = 6'h0c, OP_JMP    = 6'h0d, OP_BRREL  = 6'h0e,
		OP_BEQ    = 6'h0f, OP_BNE    = 6'h10, OP_BLT    = 6'h11,
		OP_BLTU   = 6'h12, OP_BLE    = 6'h13, OP_BLEU   = 6'h14,
		OP_BGT    = 6'h15, OP_BGTU   = 6'h16, OP_BGE    = 6'h17,
		OP_BGEU   = 6'h18, OP_TRAP   = 6'h19, OP_ERET   = 6'h1a,
		OP_BREAK  = 6'h1b, OP_BRET   = 6'h1c, OP_RDCTL  = 6'h1d,
		OP_WRCTL  = 6'h1e, OP_FLUSHP = 6'h1f, OP_SYNC   = 6'h20,
		OP_CUSTOM = 6'h21, OP_MUL    = 6'h22, OP_MULI   = 6'h23,
		OP_MULXSS = 6'h24, OP_MULXSU = 6'h25, OP_MULXUU = 6'h26,
		OP_DIV    = 6'h27, OP_DIVU   = 6'h28
	} sbc_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CUST = 3'b010,
		ST_SYNC = 3'b100
	} sbc_state_t;

endpackage

// File: hdl/sbc_custom_if.sv
// Interface carrying the handshake to the custom instruction logic.
interface sbc_custom_if
	import sbc_pkg::*;
	();

	logic            start;
	logic [XLEN-1:0] opa;
	logic [XLEN-1:0] opb;
	logic            done;
	logic [XLEN-1:0] result;

	modport core (output start, output opa, output opb,
		input done, input result);
	modport unit (input start, input opa, input opb,
		output done, output result);

endinterface

// File: hdl/sbc_shifter.sv
// Barrel shifter for the shift and rotate operations.
module sbc_shifter
	import sbc_pkg::*;
	(
	// Operation and operands
	input  wire sbc_op_t            op,
	input  wire logic [XLEN-1:0]    src,
	input  wire logic [SHAMT_W-1:0] amt,
	// Result
	output logic      [XLEN-1:0]    res
	);

	logic [2*XLEN-1:0] rot_l;
	logic [2*XLEN-1:0] rot_r;

	always_comb begin
		rot_l = {src, src} << amt;
		rot_r = {src, src} >> amt;
		case (op)
			OP_ROL, OP_ROLI: res = rot_l[2*XLEN-1:XLEN]; // RQ1
			OP_ROR:          res = rot_r[XLEN-1:0]; // RQ2
			OP_SLL, OP_SLLI: res = src << amt; // RQ3
			OP_SRL, OP_SRLI: res = src >> amt; // RQ3
			OP_SRA, OP_SRAI: res = $unsigned($signed(src) >>> amt); // RQ4
			default:         res = '0;
		endcase
	end

endmodule

// File: hdl/sbc_exec.sv
// Execution unit for shift, program control and other control operations.
// How it works
// [RQ1] Left rotate takes its count from a register or the immediate.
// [RQ2] Right rotate takes its count from a register only.
// [RQ3] Logical shifts fill vacated bits with zeros.
// [RQ4] Arithmetic right shifts replicate the sign bit.
// [RQ5] Immediate shift forms take the count from the immediate field.
// [RQ6] Jumps, calls, returns and branches redirect with no delay slot.
// [RQ7] Immediate call jumps to the immediate address and saves return.
// [RQ8] Register call jumps to a register address and saves return.
// [RQ9] Return continues at the return address register.
// [RQ10] Register jump goes to a register address, saving nothing.
// [RQ11] Relative branch targets the current position plus signed offset.
// [RQ12] Conditional branches compare two registers, ten relations.
// [RQ13] Taken conditional branches kill the following instruction.
// [RQ14] Trap saves status and return address, enters the handler.
// [RQ15] Exception return restores status and resumes at saved address.
// [RQ16] Break and break-return exist for debug tooling.
// [RQ17] Control read and write move control and general registers.
// [RQ18] Pipeline flush discards all prefetched instructions.
// [RQ19] Sync holds later loads and stores until earlier ops finish.
// [RQ20] Custom op hands operands to custom logic which returns result.
// [RQ21] Multiply and divide without hardware raise unimplemented trap.
// [RQ22] Nothing else ever raises the unimplemented trap.
// [RQ23] Shift counts use only the low five bits.
module sbc_exec
	import sbc_pkg::*;
	#(
	parameter bit              HAS_MUL    = 1'b0,
	parameter bit              HAS_DIV    = 1'b0,
	parameter logic [XLEN-1:0] EXC_ADDR   = 32'h0000_0020,
	parameter logic [XLEN-1:0] BREAK_ADDR = 32'h0000_0040
	)
	(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// Issued instruction
	input  wire logic                 issue_valid,
	output logic                      issue_ready,
	input  wire sbc_op_t              op,
	input  wire logic [XLEN-1:0]      pc,
	input  wire logic [XLEN-1:0]      rs_a,
	input  wire logic [XLEN-1:0]      rs_b,
	input  wire logic [IMM_W-1:0]     imm,
	input  wire logic [CALL_IMM_W-1:0] call_imm,
	input  wire logic [CTL_SEL_W-1:0] ctl_sel,
	input  wire logic [XLEN-1:0]      return_address_reg,
	input  wire logic [XLEN-1:0]      exception_return_reg,
	input  wire logic [XLEN-1:0]      break_return_reg,
	// Completion and register writes
	output logic                      done,
	output logic                      wr_gpr,
	output logic [XLEN-1:0]           wr_data,
	output logic                      wr_ra,
	output logic                      wr_ea,
	output logic                      wr_ba,
	output logic [XLEN-1:0]           link_addr,
	// Fetch redirect
	output logic                      redirect,
	output logic [XLEN-1:0]           redirect_addr,
	output logic                      kill_next,
	output logic                      flush_pipe,
	output logic                      unimpl_exc,
	// Control registers
	output logic [XLEN-1:0]           status_q,
	output logic [XLEN-1:0]           estatus_q,
	output logic [XLEN-1:0]           bstatus_q,
	// Memory ordering
	input  wire logic                 ops_pending,
	output logic                      ldst_hold,
	// Custom instruction logic
	sbc_custom_if.core                cust
	);

	// ****************************************************************
	// Shifter
	// ****************************************************************
	logic [SHAMT_W-1:0] amt;
	logic [XLEN-1:0]    shift_res;
	logic               is_shift;
	logic               imm_cnt;

	always_comb begin
		imm_cnt = (op == OP_ROLI) || (op == OP_SLLI) ||
			(op == OP_SRLI) || (op == OP_SRAI);
		is_shift = imm_cnt || (op == OP_ROL) || (op == OP_ROR) ||
			(op == OP_SLL) || (op == OP_SRL) || (op == OP_SRA);
		amt = imm_cnt ? imm[SHAMT_W-1:0] : rs_b[SHAMT_W-1:0]; // RQ5 RQ23
	end

	sbc_shifter u_shift (
		.op  (op),
		.src (rs_a),
		.amt (amt),
		.res (shift_res)
	);

	// ****************************************************************
	// Branch conditions and targets
	// ****************************************************************
	logic            cond;
	logic [XLEN-1:0] rel_tgt;
	logic [XLEN-1:0] seq_addr;
	logic            lt_s;
	logic            lt_u;

	always_comb begin
		lt_s = $signed(rs_a) < $signed(rs_b);
		lt_u = rs_a < rs_b;
		seq_addr = pc + INSN_BYTES;
		rel_tgt = pc + {{(XLEN-IMM_W){imm[IMM_W-1]}}, imm}; // RQ11
		case (op)
			OP_BEQ:  cond = rs_a == rs_b; // RQ12
			OP_BNE:  cond = rs_a != rs_b;
			OP_BLT:  cond = lt_s;
			OP_BLTU: cond = lt_u;
			OP_BLE:  cond = lt_s || (rs_a == rs_b);
			OP_BLEU: cond = lt_u || (rs_a == rs_b);
			OP_BGT:  cond = !lt_s && (rs_a != rs_b);
			OP_BGTU: cond = !lt_u && (rs_a != rs_b);
			OP_BGE:  cond = !lt_s;
			OP_BGEU: cond = !lt_u;
			default: cond = 1'b0;
		endcase
	end

	// ****************************************************************
	// Sequencer and control registers
	// ****************************************************************
	sbc_state_t      state_q, state_d;
	logic [XLEN-1:0] status_d, estatus_d, bstatus_d;
	logic            fire;

	always_comb begin
		state_d       = state_q;
		status_d      = status_q;
		estatus_d     = estatus_q;
		bstatus_d     = bstatus_q;
		issue_ready   = 1'b0;
		fire          = 1'b0;
		done          = 1'b0;
		wr_gpr        = 1'b0;
		wr_data       = '0;
		wr_ra         = 1'b0;
		wr_ea         = 1'b0;
		wr_ba         = 1'b0;
		link_addr     = seq_addr;
		redirect      = 1'b0;
		redirect_addr = seq_addr;
		flush_pipe    = 1'b0;
		unimpl_exc    = 1'b0; // RQ22
		ldst_hold     = 1'b0;
		cust.start    = 1'b0;
		cust.opa      = rs_a;
		cust.opb      = rs_b;
		case (state_q)
			ST_IDLE: begin
				issue_ready = 1'b1;
				fire = issue_valid;
			end
			ST_CUST: begin
				if (cust.done) begin // RQ20
					done = 1'b1;
					wr_gpr = 1'b1;
					wr_data = cust.result;
					state_d = ST_IDLE;
				end
			end
			ST_SYNC: begin
				ldst_hold = 1'b1; // RQ19
				if (!ops_pending) begin
					done = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		if (fire) begin
			done = 1'b1;
			case (op)
				OP_CALL: begin
					wr_ra = 1'b1; // RQ7
					redirect = 1'b1;
					redirect_addr = {pc[XLEN-1:CALL_IMM_W+2], call_imm, 2'b00};
				end
				OP_CALLR: begin
					wr_ra = 1'b1; // RQ8
					redirect = 1'b1;
					redirect_addr = rs_a;
				end
				OP_RET: begin
					redirect = 1'b1; // RQ9
					redirect_addr = return_address_reg;
				end
				OP_JMP: begin
					redirect = 1'b1; // RQ10
					redirect_addr = rs_a;
				end
				OP_BRREL: begin
					redirect = 1'b1; // RQ11
					redirect_addr = rel_tgt;
				end
				OP_TRAP: begin
					estatus_d = status_q; // RQ14
					status_d = STATUS_RST;
					wr_ea = 1'b1;
					redirect = 1'b1;
					redirect_addr = EXC_ADDR;
				end
				OP_ERET: begin
					status_d = estatus_q; // RQ15
					redirect = 1'b1;
					redirect_addr = exception_return_reg;
				end
				OP_BREAK: begin
					bstatus_d = status_q; // RQ16
					status_d = STATUS_RST;
					wr_ba = 1'b1;
					redirect = 1'b1;
					redirect_addr = BREAK_ADDR;
				end
				OP_BRET: begin
					status_d = bstatus_q; // RQ16
					redirect = 1'b1;
					redirect_addr = break_return_reg;
				end
				OP_RDCTL: begin
					wr_gpr = 1'b1; // RQ17
					case (ctl_sel)
						CTL_STATUS:  wr_data = status_q;
						CTL_ESTATUS: wr_data = estatus_q;
						CTL_BSTATUS: wr_data = bstatus_q;
						default:     wr_data = '0;
					endcase
				end
				OP_WRCTL: begin
					case (ctl_sel) // RQ17
						CTL_STATUS:  status_d = rs_a;
						CTL_ESTATUS: estatus_d = rs_a;
						CTL_BSTATUS: bstatus_d = rs_a;
						default:     status_d = status_q;
					endcase
				end
				OP_FLUSHP: begin
					flush_pipe = 1'b1; // RQ18
					redirect = 1'b1;
					redirect_addr = seq_addr;
				end
				OP_SYNC: begin
					done = 1'b0; // RQ19
					ldst_hold = 1'b1;
					state_d = ST_SYNC;
				end
				OP_CUSTOM: begin
					done = 1'b0; // RQ20
					cust.start = 1'b1;
					state_d = ST_CUST;
				end
				OP_MUL, OP_MULI, OP_MULXSS, OP_MULXSU, OP_MULXUU: begin
					if (!HAS_MUL) begin
						unimpl_exc = 1'b1; // RQ21
						estatus_d = status_q;
						status_d = STATUS_RST;
						wr_ea = 1'b1;
						redirect = 1'b1;
						redirect_addr = EXC_ADDR;
					end
				end
				OP_DIV, OP_DIVU: begin
					if (!HAS_DIV) begin
						unimpl_exc = 1'b1; // RQ21
						estatus_d = status_q;
						status_d = STATUS_RST;
						wr_ea = 1'b1;
						redirect = 1'b1;
						redirect_addr = EXC_ADDR;
					end
				end
				default: begin
					if (is_shift) begin
						wr_gpr = 1'b1;
						wr_data = shift_res;
					end else if (cond) begin
						redirect = 1'b1; // RQ12
						redirect_addr = rel_tgt;
					end
				end
			endcase
		end
	end

	// Any redirect drops the fall-through instruction already fetched.
	assign kill_next = redirect; // RQ6 RQ13

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q   <= ST_IDLE;
			status_q  <= STATUS_RST;
			estatus_q <= STATUS_RST;
			bstatus_q <= STATUS_RST;
		end else begin
			state_q   <= state_d;
			status_q  <= status_d;
			estatus_q <= estatus_d;
			bstatus_q <= bstatus_d;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic fire_mul;
	assign fire_mul = fire && (op inside {OP_MUL, OP_MULI, OP_MULXSS,
		OP_MULXSU, OP_MULXUU, OP_DIV, OP_DIVU});

	a_unimpl_only: assert property (@(posedge clk) disable iff (sys_rst) // RQ22
		unimpl_exc |-> fire_mul) else $error("unimplemented trap on wrong op");
	a_call_link: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		fire && op == OP_CALL |-> wr_ra && redirect &&
		link_addr == pc + INSN_BYTES)
		else $error("call did not save link");
	a_ret_target: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
		fire && op == OP_RET |-> redirect_addr == return_address_reg)
		else $error("return went astray");
	a_jmp_nolink: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
		fire && op == OP_JMP |-> !wr_ra && redirect_addr == rs_a)
		else $error("jump saved link or wrong target");
	a_branch_taken: assert property (@(posedge clk) disable iff (sys_rst) // RQ13
		fire && op == OP_BEQ && rs_a == rs_b |-> kill_next)
		else $error("taken branch kept next insn");
	a_trap_save: assert property (@(posedge clk) disable iff (sys_rst) // RQ14
		fire && op == OP_TRAP |=> estatus_q == $past(status_q))
		else $error("trap lost status");
	a_eret_restore: assert property (@(posedge clk) disable iff (sys_rst) // RQ15
		fire && op == OP_ERET |=> status_q == $past(estatus_q))
		else $error("eret did not restore status");
	a_sync_hold: assert property (@(posedge clk) disable iff (sys_rst) // RQ19
		state_q == ST_SYNC && ops_pending |-> ldst_hold && !issue_ready)
		else $error("sync let loads pass");
	a_shift_sll: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
		fire && op == OP_SLL |-> wr_data == rs_a << rs_b[4:0])
		else $error("logical shift wrong");
	a_cust_result: assert property (@(posedge clk) disable iff (sys_rst) // RQ20
		state_q == ST_CUST && cust.done |-> wr_gpr && wr_data == cust.result)
		else $error("custom result lost");

	c_call: cover property (@(posedge clk) fire && op == OP_CALL);
	c_branch: cover property (@(posedge clk) fire && op == OP_BLT && cond);
	c_sync: cover property (@(posedge clk) state_q == ST_SYNC && done);
	c_unimpl: cover property (@(posedge clk) unimpl_exc);

endmodule

// File: tb/tb_shift_branch_control_exec.sv
// Self-checking testbench for the shift, branch and control execution unit.
module tb_shift_branch_control_exec
	import sbc_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Stimulus and wiring
	// ****************************************************************
	localparam logic [XLEN-1:0]       PC_C = 32'h1000_0100;
	localparam logic [XLEN-1:0]       RA_C = 32'h0000_1230;
	localparam logic [XLEN-1:0]       EA_C = 32'h0000_2340;
	localparam logic [XLEN-1:0]       BA_C = 32'h0000_3450;
	localparam logic [CALL_IMM_W-1:0] CI_C = 26'h012_3456;

	logic clk, sys_rst, issue_valid, issue_ready, ops_pending, ldst_hold;
	logic done, wr_gpr, wr_ra, wr_ea, wr_ba;
	logic redirect, kill_next, flush_pipe, unimpl_exc;
	logic [XLEN-1:0] rs_a, rs_b, wr_data, link_addr, redirect_addr;
	logic [XLEN-1:0] status_q, estatus_q, bstatus_q;
	logic [IMM_W-1:0] imm;
	logic [CTL_SEL_W-1:0] ctl_sel;
	sbc_op_t op;
	int bad_count;
	int total_checks;

	sbc_custom_if cif ();

	sbc_exec u_dut (
		.clk(clk), .sys_rst(sys_rst),
		.issue_valid(issue_valid), .issue_ready(issue_ready),
		.op(op), .pc(PC_C), .rs_a(rs_a), .rs_b(rs_b), .imm(imm),
		.call_imm(CI_C), .ctl_sel(ctl_sel),
		.return_address_reg(RA_C), .exception_return_reg(EA_C),
		.break_return_reg(BA_C),
		.done(done), .wr_gpr(wr_gpr), .wr_data(wr_data),
		.wr_ra(wr_ra), .wr_ea(wr_ea), .wr_ba(wr_ba),
		.link_addr(link_addr), .redirect(redirect),
		.redirect_addr(redirect_addr), .kill_next(kill_next),
		.flush_pipe(flush_pipe), .unimpl_exc(unimpl_exc),
		.status_q(status_q), .estatus_q(estatus_q),
		.bstatus_q(bstatus_q), .ops_pending(ops_pending),
		.ldst_hold(ldst_hold), .cust(cif.core)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(string name, logic [XLEN-1:0] seen,
		logic [XLEN-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Presents one instruction; the next edge takes it.
	task automatic go(sbc_op_t o, logic [XLEN-1:0] a, logic [XLEN-1:0] b,
		logic [IMM_W-1:0] im);
		@(posedge clk);
		op <= o;
		rs_a <= a;
		rs_b <= b;
		imm <= im;
		issue_valid <= 1'b1;
		#10;
		chk("unimpl", unimpl_exc, o inside {[OP_MUL:OP_DIVU]});
	endtask

	task automatic idle(int n);
		repeat (n) begin
			@(posedge clk);
			issue_valid <= 1'b0;
		end
		#10;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic sh(sbc_op_t o, logic [XLEN-1:0] b, logic [IMM_W-1:0] im,
		logic [XLEN-1:0] exp);
		go(o, 32'h8000_00f1, b, im);
		chk("shift", wr_data, exp);
		chk("shift_wr", {done, wr_gpr}, 2'h3);
	endtask

	task automatic t_shift();
		sh(OP_ROL, 32'h0000_0024, 16'h0000, 32'h0000_0f18);
		sh(OP_ROLI, 32'h0000_0001, 16'h0023, 32'h0000_078c);
		sh(OP_ROR, 32'h0000_0024, 16'h0003, 32'h1800_000f);
		sh(OP_SLL, 32'h0000_0024, 16'h0000, 32'h0000_0f10);
		sh(OP_SLLI, 32'h0000_0001, 16'h0003, 32'h0000_0788);
		sh(OP_SRL, 32'h0000_0024, 16'h0000, 32'h0800_000f);
		sh(OP_SRLI, 32'h0000_0001, 16'h0023, 32'h1000_001e);
		sh(OP_SRA, 32'h0000_0024, 16'h0000, 32'hf800_000f);
		sh(OP_SRAI, 32'h0000_0001, 16'h0003, 32'hf000_001e);
		$display("test shift finished");
	endtask

	task automatic jp(sbc_op_t o, logic [XLEN-1:0] a, logic [IMM_W-1:0] im,
		logic [XLEN-1:0] exp, logic exp_ra);
		go(o, a, 32'h0000_0000, im);
		chk("jump_addr", redirect_addr, exp);
		chk("jump_kill", {redirect, kill_next}, 2'h3);
		chk("jump_ra", wr_ra, exp_ra);
		if (exp_ra) begin
			chk("link", link_addr, PC_C + INSN_BYTES);
		end
	endtask

	task automatic t_jump();
		jp(OP_CALL, 32'h0, 16'h0, {PC_C[31:28], CI_C, 2'b00}, 1'b1);
		jp(OP_CALLR, 32'h0000_4000, 16'h0, 32'h0000_4000, 1'b1);
		jp(OP_RET, 32'h0, 16'h0, RA_C, 1'b0);
		jp(OP_JMP, 32'h0000_5000, 16'h0, 32'h0000_5000, 1'b0);
		jp(OP_BRREL, 32'h0, 16'hfff0, PC_C - 32'h10, 1'b0);
		$display("test jump finished");
	endtask

	task automatic t_branch();
		logic [9:0] m1;
		logic [9:0] m2;
		m1 = 10'h296;
		m2 = 10'h331;
		for (int i = 0; i < 10; i++) begin
			go(sbc_op_t'(6'h0f + 6'(i)), 32'hffff_ffff, 32'h0000_0001, 16'h0010);
			chk("br_diff", {redirect, kill_next}, {2{m1[i]}});
			if (m1[i]) begin
				chk("br_tgt", redirect_addr, PC_C + 32'h10);
			end
			go(sbc_op_t'(6'h0f + 6'(i)), 32'h0000_0005, 32'h0000_0005, 16'h0010);
			chk("br_eq", {redirect, kill_next}, {2{m2[i]}});
		end
		$display("test branch finished");
	endtask

	task automatic t_exc();
		@(posedge clk);
		issue_valid <= 1'b0;
		ctl_sel <= CTL_STATUS;
		go(OP_WRCTL, 32'h0000_0005, 32'h0, 16'h0);
		go(OP_TRAP, 32'h0, 32'h0, 16'h0);
		chk("trap_st", status_q, 32'h0000_0005);
		chk("trap_go", {redirect, wr_ea}, 2'h3);
		chk("trap_addr", redirect_addr, 32'h0000_0020);
		chk("trap_link", link_addr, PC_C + INSN_BYTES);
		go(OP_ERET, 32'h0, 32'h0, 16'h0);
		chk("estatus", estatus_q, 32'h0000_0005);
		chk("eret_addr", redirect_addr, EA_C);
		go(OP_BREAK, 32'h0, 32'h0, 16'h0);
		chk("eret_st", status_q, 32'h0000_0005);
		chk("brk", {redirect, wr_ba}, 2'h3);
		chk("brk_addr", redirect_addr, 32'h0000_0040);
		go(OP_BRET, 32'h0, 32'h0, 16'h0);
		chk("bstatus", bstatus_q, 32'h0000_0005);
		chk("bret_addr", redirect_addr, BA_C);
		for (int s = 1; s < 6; s += 4) begin
			@(posedge clk);
			issue_valid <= 1'b0;
			ctl_sel <= 3'(s);
			go(OP_RDCTL, 32'h0, 32'h0, 16'h0);
			chk("rdctl", wr_data, s == 1 ? 32'h0000_0005 : 32'h0);
		end
		go(OP_FLUSHP, 32'h0, 32'h0, 16'h0);
		chk("flush", {flush_pipe, redirect}, 2'h3);
		chk("flush_addr", redirect_addr, PC_C + INSN_BYTES);
		$display("test control finished");
	endtask

	task automatic t_wait();
		@(posedge clk);
		issue_valid <= 1'b0;
		ops_pending <= 1'b1;
		go(OP_SYNC, 32'h0, 32'h0, 16'h0);
		chk("sync_hold", {ldst_hold, done}, 2'h2);
		idle(2);
		chk("sync_wait", {ldst_hold, issue_ready}, 2'h2);
		@(posedge clk);
		ops_pending <= 1'b0;
		#10;
		chk("sync_done", done, 1'b1);
		idle(1);
		chk("sync_end", {ldst_hold, issue_ready}, 2'h1);
		go(OP_CUSTOM, 32'h0000_1111, 32'h0000_2222, 16'h0);
		chk("cust_go", {cif.start, done}, 2'h2);
		chk("cust_a", cif.opa, 32'h0000_1111);
		chk("cust_b", cif.opb, 32'h0000_2222);
		idle(3);
		chk("cust_wait", {issue_ready, done}, 2'h0);
		@(posedge clk);
		cif.done <= 1'b1;
		cif.result <= 32'h0000_cafe;
		#10;
		chk("cust_done", {done, wr_gpr}, 2'h3);
		chk("cust_res", wr_data, 32'h0000_cafe);
		@(posedge clk);
		cif.done <= 1'b0;
		cif.result <= 32'hffff_3501;
		for (int k = 0; k < 7; k++) begin
			go(sbc_op_t'(6'h22 + 6'(k)), 32'h0000_0003, 32'h0000_0007, 16'h0);
		end
		idle(1);
		$display("test wait finished");
	endtask

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		bad_count = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		issue_valid = 1'b0;
		ops_pending = 1'b0;
		op = OP_NOP;
		rs_a = 32'h0;
		rs_b = 32'h0;
		imm = 16'h0;
		ctl_sel = CTL_STATUS;
		cif.done = 1'b0;
		cif.result = 32'h0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		t_shift();
		t_jump();
		t_branch();
		t_exc();
		t_wait();
		report_and_stop();
	end

	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end

endmodule
